// File: core/nssd_core.sv
/*
 * Decode and execute slice: bit-test skips, stop with wake-up, and
 * three nibble subtracts. Assumes the fetch side presents one word
 * per cycle with instr_valid, and a combinational data memory read.
 */
`timescale 1ns/1ns
// Contract
// - Decode bit-two skip with seven-bit address
// - Bit two set skips, else step one
// - Decode bit-three skip with seven-bit address
// - Bit three set skips, else step one
// - All-zero word stops the oscillator
// - Wake-port falling edge resumes next instruction
// - Memory minus accumulator into accumulator only
// - Register minus immediate into accumulator only
// - Memory minus accumulator into both
module nssd_core
    import nssd_pkg::*;
#(
    parameter int unsigned PC_W = NSSD_PCW
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Instruction fetch
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    output logic [10:0] pc,
    // Data memory
    output logic [6:0] mem_addr,
    input wire logic [3:0] mem_rdata,
    output logic [3:0] mem_wdata,
    output logic mem_we,
    // Wake-up
    input wire logic wakeup_port,
    // Status
    output logic [3:0] accumulator,
    output logic carry_flag,
    output logic zero_flag,
    output logic osc_run,
    output logic unknown_op
);
    ////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (PC_W != NSSD_PCW) begin : g_chk_pcw
        $error("nssd_core: PC_W must equal the 11-bit program counter");
    end
    if (NSSD_IW != 16) begin : g_chk_iw
        $error("nssd_core: instruction words must be 16 bits");
    end
    if (NSSD_AW != 7) begin : g_chk_aw
        $error("nssd_core: data addresses must be 7 bits");
    end
    if (NSSD_OPC_LSB + 9 != NSSD_IW) begin : g_chk_opc
        $error("nssd_core: nine-bit opcode must end the word");
    end
    if (NSSD_OPI_LSB + 8 != NSSD_IW) begin : g_chk_opi
        $error("nssd_core: eight-bit opcode must end the word");
    end
    if (NSSD_IMM_LSB + 4 != NSSD_OPI_LSB) begin : g_chk_imm
        $error("nssd_core: immediate must sit below the opcode");
    end
    if (NSSD_OP_SKIP2 == NSSD_OP_SKIP3) begin : g_chk_skip
        $error("nssd_core: skip opcodes must differ");
    end
    if (NSSD_OP_SUBM == NSSD_OP_SUBMW) begin : g_chk_sub
        $error("nssd_core: subtract opcodes must differ");
    end
    if (NSSD_OP_STOP != 9'h000) begin : g_chk_stop
        $error("nssd_core: stop word must be all zero");
    end
    if (NSSD_OP_SUBI == NSSD_OP_SUBM[8:1]) begin : g_chk_subi
        $error("nssd_core: immediate subtract must not alias");
    end

    ////////////////////////////////////////////////////////////////////
    // Opcode match
    function automatic logic op9_is(input logic [15:0] word,
                                    input logic [8:0] code);
        return word[15:NSSD_OPC_LSB] == code;
    endfunction

    function automatic logic op8_is(input logic [15:0] word,
                                    input logic [7:0] code);
        return word[15:NSSD_OPI_LSB] == code;
    endfunction

    typedef struct packed {
        nssd_state_t state;
        logic [10:0] pc;
        logic [3:0] acc;
        logic cf;
        logic zf;
        logic wake_prev;
        logic [3:0] wdata;
        logic we;
        logic unk;
    } nssd_regs_t;

    nssd_regs_t r;
    nssd_regs_t next_r;
    logic [3:0] sub_a;
    logic [3:0] sub_b;
    logic [3:0] diff;
    logic cout;
    logic zout;
    logic is_skip2;
    logic is_skip3;
    logic is_stop;
    logic is_subm;
    logic is_submw;
    logic is_subi;
    logic skip_taken;
    logic sub_any;

    ////////////////////////////////////////////////////////////////////
    // Decode
    always_comb begin
        is_skip2 = op9_is(instr, NSSD_OP_SKIP2);
        is_skip3 = op9_is(instr, NSSD_OP_SKIP3);
        is_stop = op9_is(instr, NSSD_OP_STOP);
        is_subm = op9_is(instr, NSSD_OP_SUBM);
        is_submw = op9_is(instr, NSSD_OP_SUBMW);
        is_subi = op8_is(instr, NSSD_OP_SUBI);
        sub_any = is_subm || is_submw || is_subi;
        skip_taken = (is_skip2 && mem_rdata[2])
            || (is_skip3 && mem_rdata[3]);
        if (is_subi) begin
            mem_addr = {3'h0, NSSD_WR_BASE | instr[3:0]};
        end else begin
            mem_addr = instr[6:0];
        end
        sub_a = mem_rdata;
        if (is_subi) begin
            sub_b = instr[NSSD_IMM_LSB +: 4];
        end else begin
            sub_b = r.acc;
        end
    end

    nssd_alu u_alu (
        .minuend(sub_a),
        .subtrahend(sub_b),
        .difference(diff),
        .carry_out(cout),
        .zero_out(zout)
    );

    ////////////////////////////////////////////////////////////////////
    // Execute
    always_comb begin
        next_r = r;
        next_r.we = 1'b0;
        next_r.unk = 1'b0;
        next_r.wake_prev = wakeup_port;
        case (r.state)
            NSSD_RUN: begin
                if (instr_valid) begin
                    next_r.pc = r.pc + NSSD_PC_ONE;
                    if (skip_taken) begin
                        next_r.pc = r.pc + NSSD_PC_TWO;
                    end else if (is_stop) begin
                        next_r.state = NSSD_STOPPED;
                    end else if (sub_any) begin
                        next_r.acc = diff;
                        next_r.cf = cout;
                        next_r.zf = zout;
                        if (is_submw) begin
                            next_r.we = 1'b1;
                            next_r.wdata = diff;
                        end
                    end else if (!is_skip2 && !is_skip3) begin
                        next_r.unk = 1'b1;
                    end
                end
            end
            NSSD_STOPPED: begin
                if (r.wake_prev && !wakeup_port) begin
                    next_r.state = NSSD_WAKE;
                end
            end
            NSSD_WAKE: begin
                next_r.state = NSSD_RUN;
            end
            default: begin
                next_r.state = NSSD_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{
                state: NSSD_RUN,
                pc: NSSD_PC_RST,
                acc: NSSD_NIB_RST,
                cf: 1'b0,
                zf: 1'b0,
                wake_prev: 1'b1,
                wdata: NSSD_NIB_RST,
                we: 1'b0,
                unk: 1'b0
            };
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign pc = r.pc;
    assign mem_wdata = r.wdata;
    assign mem_we = r.we;
    assign accumulator = r.acc;
    assign carry_flag = r.cf;
    assign zero_flag = r.zf;
    assign osc_run = (r.state != NSSD_STOPPED);
    assign unknown_op = r.unk;
endmodule

// File: core/nssd_pkg.sv
/*
 * Package for the nibble skip, subtract and stop decode slice.
 * Assumes 16-bit instruction words and 4-bit data nibbles.
 */
package nssd_pkg;
    localparam int unsigned NSSD_IW = 16;
    localparam int unsigned NSSD_AW = 7;
    localparam int unsigned NSSD_PCW = 11;
    localparam logic [8:0] NSSD_OP_SKIP2 = 9'h114;
    localparam logic [8:0] NSSD_OP_SKIP3 = 9'h115;
    localparam logic [8:0] NSSD_OP_STOP = 9'h000;
    localparam logic [8:0] NSSD_OP_SUBM = 9'h034;
    localparam logic [8:0] NSSD_OP_SUBMW = 9'h036;
    localparam logic [7:0] NSSD_OP_SUBI = 8'h1e;
    localparam int unsigned NSSD_OPC_LSB = 7;
    localparam int unsigned NSSD_OPI_LSB = 8;
    localparam int unsigned NSSD_IMM_LSB = 4;
    localparam logic [10:0] NSSD_PC_RST = 11'h000;
    localparam logic [10:0] NSSD_PC_ONE = 11'h001;
    localparam logic [10:0] NSSD_PC_TWO = 11'h002;
    localparam logic [3:0] NSSD_NIB_RST = 4'h0;
    localparam logic [3:0] NSSD_WR_BASE = 4'h0;
    typedef enum logic [1:0] {
        NSSD_RUN = 2'b00,
        NSSD_STOPPED = 2'b01,
        NSSD_WAKE = 2'b11
    } nssd_state_t;
endpackage

// File: core/nssd_alu.sv
/*
 * Four-bit subtractor with borrow-reflecting carry and zero flag.
 * Assumes purely combinational use from the decode core.
 */
`timescale 1ns/1ns
module nssd_alu
    import nssd_pkg::*;
(
    // Operands
    input wire logic [3:0] minuend,
    input wire logic [3:0] subtrahend,
    // Result
    output logic [3:0] difference,
    output logic carry_out,
    output logic zero_out
);
    logic [4:0] wide;

    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        difference = wide[3:0];
        // Carry set when no borrow
        carry_out = ~wide[4];
        zero_out = (wide[3:0] == 4'h0);
    end
endmodule

// File: testbench/nssd_assertions.sv
/* Port checker for nssd_core.
   Bound onto every nssd_core instance. */
`timescale 1ns/1ns
module nssd_chk
    import nssd_pkg::*;
(
    // Watched ports
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic [10:0] pc,
    input wire logic [3:0] mem_rdata,
    input wire logic [3:0] mem_wdata,
    input wire logic mem_we,
    input wire logic wakeup_port,
    input wire logic [3:0] accumulator,
    input wire logic carry_flag,
    input wire logic zero_flag,
    input wire logic osc_run
);
    logic was_run;
    wire ex = instr_valid & osc_run & was_run;
    wire [8:0] op = instr[15:7];
    wire [3:0] m = mem_rdata;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge mclk) was_run <= osc_run;
    AST_SKIP2: assert property (
        ex && op == NSSD_OP_SKIP2 |=>
        pc == $past(pc) + ($past(m[2]) ? 11'h2 : 11'h1)) else $error("skip2");
    AST_SKIP3: assert property (
        ex && op == NSSD_OP_SKIP3 |=>
        pc == $past(pc) + ($past(m[3]) ? 11'h2 : 11'h1)) else $error("skip3");
    AST_STOP: assert property (
        ex && op == NSSD_OP_STOP |=> !osc_run)
        else $error("stop");
    AST_WAKE: assert property (
        !osc_run && $fell(wakeup_port) |=> osc_run) else $error("wake");
    AST_SUBM: assert property (
        ex && op == NSSD_OP_SUBM |=> !mem_we &&
        accumulator == $past(m) - $past(accumulator)) else $error("subm");
    AST_SUBMW: assert property (
        ex && op == NSSD_OP_SUBMW |=> mem_we &&
        mem_wdata == accumulator && accumulator == $past(m) - $past(accumulator))
        else $error("submw");
    AST_SUBI: assert property (
        ex && instr[15:8] == NSSD_OP_SUBI |=>
        accumulator == $past(m) - $past(instr[7:4]) && !mem_we)
        else $error("subi");
    AST_FLAGI: assert property (
        ex && instr[15:8] == NSSD_OP_SUBI |=>
        carry_flag == ($past(m) >= $past(instr[7:4]))
        && zero_flag == (accumulator == 4'h0)) else $error("flags imm");
    AST_FLAG: assert property (
        ex && op[8:2] == 7'h0d && !op[0] |=>
        carry_flag == ($past(m) >= $past(accumulator))
        && zero_flag == !accumulator) else $error("flags");
    cover property (ex && op == NSSD_OP_SKIP3 && m[3]);
    cover property ($fell(wakeup_port));
    cover property (mem_we);
endmodule
bind nssd_core nssd_chk nssd_chk_i (.*);

// File: testbench/testbench.sv
/* Bench for nssd_core with a bench-held nibble memory.
   Assumes the checker is bound in. */
`timescale 1ns/1ns
module testbench;
    import nssd_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] instr = 16'h0;
    logic instr_valid = 1'b0;
    logic wakeup_port = 1'b1;
    logic [3:0] mem_rdata, mem_wdata, accumulator;
    logic [6:0] mem_addr;
    logic [10:0] pc, p;
    logic mem_we, carry_flag, zero_flag, osc_run, unknown_op;
    logic unk_seen = 1'b0;
    logic [6:0] wr_addr;
    logic [3:0] mem [128];
    int n_mismatch = 0;
    int cmp_count = 0;
    always #5 mclk = ~mclk;
    nssd_core nssd_core_i (.*);
    assign mem_rdata = mem[mem_addr];
    // Write lands one cycle after execute, at the latched address
    always @(posedge mclk) begin
        wr_addr <= mem_addr;
        if (mem_we) begin
            mem[wr_addr] <= mem_wdata;
        end
        if (unknown_op) begin
            unk_seen <= 1'b1;
        end
    end
    task automatic chk(string s, logic [10:0] e, logic [10:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic run(logic [15:0] w);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic t_skip;
        for (int i = 0; i < 4; i++) begin
            mem[i] = i[0] ? 4'hc : 4'h3;
            p = pc;
            run({i[1] ? NSSD_OP_SKIP3 : NSSD_OP_SKIP2, 7'(i)});
            chk("pc", p + (i[0] ? 11'h2 : 11'h1), pc);
        end
        $display("skip done");
    endtask
    task automatic t_sub;
        mem[2] = 4'h3;
        run({NSSD_OP_SUBI, 8'h52});
        chk("subi", 6'h38, {accumulator, carry_flag, zero_flag});
        chk("wr2", 4'h3, mem[2]);
        mem[9] = 4'h2;
        run({NSSD_OP_SUBMW, 7'h9});
        chk("submw", 6'h10, {accumulator, carry_flag, zero_flag});
        chk("wr9", 4'h4, mem[9]);
        mem[5] = 4'h4;
        run({NSSD_OP_SUBM, 7'h5});
        chk("subm", 6'h3, {accumulator, carry_flag, zero_flag});
        chk("wr5", 4'h4, mem[5]);
        chk("unk", 1'b0, unk_seen);
        p = pc;
        run(16'hffff);
        chk("unk", 1'b1, unk_seen);
        chk("pc", p + 11'h1, pc);
        $display("sub done");
    endtask
    task automatic t_stop;
        p = pc;
        run(16'h0);
        chk("run", 1'b0, osc_run);
        run({NSSD_OP_SUBI, 8'h12});
        chk("pc", p + 11'h1, pc);
        wakeup_port <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("run", 1'b1, osc_run);
        wakeup_port <= 1'b1;
        run({NSSD_OP_SUBI, 8'h12});
        chk("acc", 4'h2, accumulator);
        chk("pc", p + 11'h2, pc);
        $display("stop done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_skip;
        t_sub;
        t_stop;
        test_done;
    end
    initial begin
        repeat (500) @(posedge mclk);
        n_mismatch++;
        test_done;
    end
endmodule
